// *** bench/ifp_pmem_model.sv ***
// program memory model answering fetches quickly or slowly
`timescale 1ns/1ps
module ifp_pmem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic imem_rd,
  input wire logic [13:0] imem_addr,
  output logic [15:0] imem_rdata
);
  logic [15:0] mem [0:16383];
  int cnt;
  initial
  begin
    foreach (mem[k]) mem[k] = 16'h0000;
  end
  // lines toggle until the word is ready, so a stale word never passes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 0;
      imem_rdata <= 16'hFFFF;
    end
    else if (imem_rd)
    begin
      cnt <= slow ? 2 : 1;
      imem_rdata <= ~imem_rdata;
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      imem_rdata <= mem[imem_addr];
    end
    else if (cnt > 1)
    begin
      cnt <= cnt - 1;
      imem_rdata <= ~imem_rdata;
    end
  end
endmodule : ifp_pmem_model

// *** bench/tb_top.sv ***
// self-checking bench for the fetch core over AHB-Lite
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, imem_rd, irq_req, irq_ack, stack_push, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [13:0] imem_addr, irq_vector, stack_push_addr, p;
  logic [15:0] imem_rdata;
  logic [13:0] trace[$];
  int tcyc[$];
  int cyc = 0, fail_count = 0, compares = 0, pushes = 0, n, i, dum;
  logic [15:0] prog [11] = '{16'h2000, 16'h4000, 16'h2055, 16'h210F, 16'h223C, 16'h23A5, 16'h6000,
    16'h2011, 16'h4000, 16'hE040, 16'h2077};
  logic [13:0] tail [4] = '{14'h0040, 14'h0041, 14'h0280, 14'h0281};
  ifp_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .imem_addr(imem_addr), .imem_rd(imem_rd), .imem_rdata(imem_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .stack_push(stack_push),
    .stack_push_addr(stack_push_addr));
  ifp_pmem_model pm (.hclk(hclk), .hresetn(hresetn), .slow(slow), .imem_rd(imem_rd),
    .imem_addr(imem_addr), .imem_rdata(imem_rdata));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // sampled mid-cycle, where phase outputs are settled
  always @(negedge hclk)
  begin
    cyc++;
    if (hresetn && imem_rd === 1'b1)
    begin
      trace.push_back(imem_addr);
      tcyc.push_back(cyc);
    end
    if (stack_push === 1'b1) pushes++;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task wait_rdy(output logic [31:0] d);
    logic r;
    for (int k = 0; k < 20; k++)
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    fail_count++;
    finish_test();
  endtask : wait_rdy
  task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_rdy(rd);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : bus
  task wait_trace(input int sz);
    for (int k = 0; k < 400; k++)
    begin
      if (trace.size() >= sz) return;
      @(posedge hclk);
    end
    fail_count++;
    finish_test();
  endtask : wait_trace
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_req = 1'b0;
    irq_vector = 14'h0;
    slow = 1'b0;
    #1;
    foreach (prog[k]) pm.mem[k] = prog[k];
    pm.mem[14'h0040] = 16'hC280;
    pm.mem[14'h0041] = 16'h2033;
    repeat (15) @(posedge hclk);
    @(negedge hclk);
    `CHK("rst_addr", 14'h0000, imem_addr)
    `CHK("rst_ready", 1'b1, hreadyout)
    `CHK("rst_push", 1'b0, stack_push)
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(8'h04, 1'b0, 32'h0);
    `CHK("ctrl_rst", 32'h00000001, rd)
    wait_trace(15);
    for (i = 0; i < 15; i++)
    begin
      `CHK("fetch", (i < 11) ? 14'(i) : tail[i - 11], trace[i])
      if (i > 0) `CHK("t1_gap", 4, tcyc[i] - tcyc[i - 1])
    end
    // cleared early so a pre-jump fetch is kept whatever the phase at the write
    trace.delete();
    bus(8'h08, 1'b0, 32'h0);
    `CHK("acc", 8'hA9, rd[15:8])
    `CHK("call_push", 1, pushes)
    `CHK("ret_addr", 14'h0041, stack_push_addr)
    // low byte jump with the slow memory answer
    slow <= 1'b1;
    dum = 0;
    bus(8'h00, 1'b1, 32'h00000010);
    for (i = 0; i < 8; i++)
    begin
      bus(8'h08, 1'b0, 32'h0);
      if (rd[4] === 1'b0) dum++;
    end
    `CHK("dummy_seen", 1'b1, dum > 0)
    wait_trace(10);
    n = -1;
    for (i = 0; i < 9; i++) if (n < 0 && trace[i][7:0] === 8'h10) n = i;
    `CHK("pcl_jump", 1'b1, n > 0)
    if (n > 0)
    begin
      `CHK("pcl_tgt", 14'h0210, trace[n])
      `CHK("pcl_next", 14'h0211, trace[n + 1])
      `CHK("pcl_page", 6'h02, trace[n - 1][13:8])
    end
    // frozen sequencer: reads must not move program flow
    bus(8'h04, 1'b1, 32'h0);
    bus(8'h04, 1'b0, 32'h0);
    `CHK("ctrl_rw", 32'h00000000, rd)
    bus(8'h0C, 1'b0, 32'h0);
    p = rd[13:0];
    bus(8'h00, 1'b0, 32'h0);
    `CHK("pcl_read", p[7:0], rd[7:0])
    bus(8'h10, 1'b0, 32'h0);
    `CHK("ir_nop", 32'h00000000, rd)
    bus(8'h20, 1'b0, 32'h0);
    `CHK("unmapped", 32'h00000000, rd)
    `CHK("resp_okay", 1'b0, hresp)
    bus(8'h20, 1'b1, 32'hFFFFFFFF);
    bus(8'h0C, 1'b0, 32'h0);
    `CHK("pc_hold", p, rd[13:0])
    bus(8'h08, 1'b0, 32'h0);
    `CHK("phase_onehot", 1, $countones(rd[3:0]))
    // interrupt entry loads the vector
    bus(8'h04, 1'b1, 32'h00000003);
    irq_vector <= 14'h0300;
    irq_req <= 1'b1;
    trace.delete();
    for (i = 0; i < 60 && irq_ack !== 1'b1; i++) @(negedge hclk);
    `CHK("irq_ack", 1'b1, irq_ack)
    @(posedge hclk);
    irq_req <= 1'b0;
    wait_trace(6);
    n = 0;
    foreach (trace[k]) if (trace[k] === 14'h0300) n = 1;
    `CHK("irq_fetch", 1, n)
    `CHK("irq_push", 2, pushes)
    finish_test();
  end
endmodule : tb_top

// *** hdl/ifp_alu.sv ***
// 8-bit accumulator arithmetic-logic unit
`timescale 1ns/1ps
module ifp_alu #(
  parameter int W = 8
) (
  input wire ifp_pkg::ifp_aluop_t op,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] y
);

  // carry is dropped: the status word at 0x08 holds no carry flag
  always_comb
  begin
    case (op)
      ifp_pkg::ALU_MOV: y = b;
      ifp_pkg::ALU_ADD: y = W'(a + b);
      ifp_pkg::ALU_AND: y = a & b;
      ifp_pkg::ALU_XOR: y = a ^ b;
      default: y = b;
    endcase
  end

endmodule : ifp_alu

// *** hdl/ifp_core.sv ***
// instruction fetch pipeline and program counter with AHB-Lite registers
`timescale 1ns/1ps
`include "ifp_params.svh"

// Notes on behaviour
// - four non-overlapping phases from hclk; one full round is an instruction cycle.
// - program counter advances and a new fetch starts at first phase.
// - decode and execute occupy phases two, three and four.
// - next fetch overlaps current execute; plain instructions finish one per cycle.
// - jumps and calls take two cycles: target first, then branch.
// - without a redirect the program counter grows by exactly one.
// - jump, call, interrupt and reset load the target directly.
// - a taken skip drops the prefetched word and runs a dummy cycle.
// - software writes only the low byte of the program counter; the full counter reads at 0x0C.
// - writing the low byte jumps inside the current 256-word page.
// - a low byte write inserts one dummy cycle before the new instruction.
// - execution uses an 8-bit ALU with data through the accumulator.
// - a low byte write keeps the upper program counter bits.
// - after reset execution starts at address zero.
module ifp_core #(
  parameter int PC_W = 14,
  parameter int IR_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [PC_W-1:0] imem_addr,
  output logic imem_rd,
  input wire logic [IR_W-1:0] imem_rdata,
  input wire logic irq_req,
  input wire logic [PC_W-1:0] irq_vector,
  output logic irq_ack,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_addr
);

  function automatic ifp_pkg::ifp_cls_t dec_cls(input logic [IR_W-1:0] ir);
    case (ir[`IFP_OP_HI:`IFP_OP_LO])
      ifp_pkg::OP_ALU: dec_cls = ifp_pkg::CLS_ALU;
      ifp_pkg::OP_SKZ: dec_cls = ifp_pkg::CLS_SKZ;
      ifp_pkg::OP_SKNZ: dec_cls = ifp_pkg::CLS_SKNZ;
      ifp_pkg::OP_CALL: dec_cls = ifp_pkg::CLS_CALL;
      ifp_pkg::OP_JMP: dec_cls = ifp_pkg::CLS_JMP;
      default: dec_cls = ifp_pkg::CLS_NOP;
    endcase
  endfunction : dec_cls

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = PC_W'(pc + 1'b1);
  endfunction : pc_inc

  ifp_pkg::ifp_phase_t phase;
  ifp_pkg::ifp_ahb_ap_t ap_q;
  ifp_pkg::ifp_redir_t redir_q;
  ifp_pkg::ifp_cls_t cls_q;
  logic [1:0] ctrl_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_word;
  logic [PC_W-1:0] pc_q;
  logic [IR_W-1:0] ir_q;
  logic exec_vld_q;
  logic [7:0] acc_q;
  logic [7:0] alu_q;
  logic [7:0] alu_y;
  logic pcl_pend_q;
  logic [7:0] pcl_dat_q;
  logic irq_ack_q;
  logic push_q;
  logic [PC_W-1:0] push_addr_q;
  logic started_q;
  logic run;
  logic t2;
  logic t3;
  logic cyc_end;
  logic ap_take;
  logic wr_now;
  logic pcl_wr_now;
  logic pcl_apply;
  logic [7:0] pcl_val;
  logic redirect_now;
  logic skip_taken;
  logic irq_take;

  assign run = ctrl_q[`IFP_CTRL_RUN];
  assign t2 = run && phase == ifp_pkg::IFP_T2;
  assign t3 = run && phase == ifp_pkg::IFP_T3;
  assign cyc_end = run && phase == ifp_pkg::IFP_T4;

  ifp_phase_gen u_phase (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .phase_q(phase)
  );

  ifp_alu #(.W(8)) u_alu (
    .op(ifp_pkg::ifp_aluop_t'(ir_q[`IFP_AOP_HI:`IFP_AOP_LO])),
    .a(acc_q),
    .b(ir_q[`IFP_IMM_HI:0]),
    .y(alu_y)
  );

  // bus slave: writes take no wait state, reads one
  assign ap_take = hsel && hready && htrans[1];
  assign wr_now = ap_q.vld && ap_q.wr;
  assign pcl_wr_now = wr_now && ap_q.addr == `IFP_OFS_PCL;
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ap_q <= '0;
    else if (hready)
    begin
      ap_q.vld <= ap_take;
      ap_q.wr <= hwrite;
      ap_q.addr <= haddr[7:0];
    end
  end

  // sampling in the wait state lets a read follow a write to the same register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_wait_q <= 1'b0;
    else
      rd_wait_q <= ap_take && !hwrite;
  end

  always_comb
  begin
    case (ap_q.addr)
      `IFP_OFS_PCL: rd_word = {24'h000000, pc_q[7:0]};
      `IFP_OFS_CTRL: rd_word = {30'h00000000, ctrl_q};
      `IFP_OFS_STAT: rd_word = {16'h0000, acc_q, 2'h0, pcl_pend_q, exec_vld_q, phase};
      `IFP_OFS_PC: rd_word = 32'(pc_q);
      `IFP_OFS_IR: rd_word = 32'(ir_q);
      default: rd_word = 32'h00000000;
    endcase
  end

  // reads have no side effect on program flow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (rd_wait_q)
      hrdata_q <= rd_word;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= `IFP_CTRL_RST;
    else if (wr_now && ap_q.addr == `IFP_OFS_CTRL)
      ctrl_q <= hwdata[1:0];
  end

  // a branch from the instruction stream wins; the low byte write then waits a cycle
  assign pcl_apply = cyc_end && !redir_q.vld && (pcl_pend_q || pcl_wr_now);
  assign pcl_val = pcl_wr_now ? hwdata[7:0] : pcl_dat_q;
  assign redirect_now = pcl_apply || (cyc_end && redir_q.vld);

  // a new write in the apply cycle is used at once, so none is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcl_pend_q <= 1'b0;
      pcl_dat_q <= 8'h00;
    end
    else
    begin
      pcl_pend_q <= (pcl_pend_q || pcl_wr_now) && !pcl_apply;
      if (pcl_wr_now)
        pcl_dat_q <= hwdata[7:0];
    end
  end

  // fetch address is live for the whole cycle; memory answers by the fourth phase
  assign imem_addr = pc_q;
  assign imem_rd = run && phase == ifp_pkg::IFP_T1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pc_q <= PC_W'(`IFP_PC_RST);
    else if (pcl_apply)
      pc_q <= {pc_q[PC_W-1:`IFP_PAGE_LO], pcl_val};
    else if (cyc_end && redir_q.vld)
      pc_q <= redir_q.tgt;
    else if (cyc_end)
      pc_q <= pc_inc(pc_q);
  end

  // the word fetched this cycle executes next; a redirect turns it into a dummy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ir_q <= '0;
      exec_vld_q <= 1'b0;
    end
    else if (cyc_end)
    begin
      ir_q <= imem_rdata;
      exec_vld_q <= !redirect_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cls_q <= ifp_pkg::CLS_NOP;
    else if (t2)
      cls_q <= exec_vld_q ? dec_cls(ir_q) : ifp_pkg::CLS_NOP;
  end

  assign skip_taken = (cls_q == ifp_pkg::CLS_SKZ && acc_q == 8'h00)
    || (cls_q == ifp_pkg::CLS_SKNZ && acc_q != 8'h00);
  assign irq_take = t3 && ctrl_q[`IFP_CTRL_IRQEN] && irq_req
    && cls_q != ifp_pkg::CLS_JMP && cls_q != ifp_pkg::CLS_CALL && !skip_taken;

  // pc_q already points past the current instruction, so it is the return address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      redir_q <= '0;
    else if (cyc_end)
      redir_q <= '0;
    else if (t3)
    begin
      redir_q <= '0;
      case (cls_q)
        ifp_pkg::CLS_JMP,
        ifp_pkg::CLS_CALL:
        begin
          redir_q.vld <= 1'b1;
          redir_q.push <= cls_q == ifp_pkg::CLS_CALL;
          redir_q.tgt <= {pc_q[PC_W-1:`IFP_TGT_HI+1], ir_q[`IFP_TGT_HI:0]};
        end
        ifp_pkg::CLS_SKZ,
        ifp_pkg::CLS_SKNZ:
        begin
          redir_q.vld <= skip_taken;
          redir_q.tgt <= pc_inc(pc_q);
        end
        default:
        begin
          redir_q.vld <= irq_take;
          redir_q.push <= irq_take;
          redir_q.tgt <= irq_vector;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_ack_q <= 1'b0;
    else
      irq_ack_q <= irq_take;
  end

  assign irq_ack = irq_ack_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      push_q <= 1'b0;
      push_addr_q <= '0;
    end
    else
    begin
      push_q <= cyc_end && redir_q.vld && redir_q.push;
      if (cyc_end && redir_q.vld && redir_q.push)
        push_addr_q <= pc_q;
    end
  end

  assign stack_push = push_q;
  assign stack_push_addr = push_addr_q;

  // accumulator: operate in the third phase, write back at the end of the fourth
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alu_q <= `IFP_ACC_RST;
    else if (t3)
      alu_q <= alu_y;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_q <= `IFP_ACC_RST;
    else if (cyc_end && cls_q == ifp_pkg::CLS_ALU)
      acc_q <= alu_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      started_q <= 1'b0;
    else if (cyc_end)
      started_q <= 1'b1;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence dummy_cyc;
    !exec_vld_q [*4];
  endsequence

  reset_start_a: assert property (!started_q |-> pc_q == '0 && !exec_vld_q)
    else $error("first fetch not from address zero");

  pc_step_a: assert property (cyc_end && !redirect_now |=> pc_q == pc_inc($past(pc_q)))
    else $error("program counter did not step by one");

  // a stop written at the wrap may hold the sequencer in the first phase
  overlap_a: assert property (cyc_end && !redirect_now |=> exec_vld_q && phase == ifp_pkg::IFP_T1)
    else $error("plain instruction did not follow back to back");

  decide_t3_a: assert property ($rose(redir_q.vld) |-> $past(phase) == ifp_pkg::IFP_T3)
    else $error("redirect decided outside third phase");

  load_tgt_a: assert property (cyc_end && redir_q.vld |=> pc_q == $past(redir_q.tgt) ##0 dummy_cyc)
    else $error("target not loaded or no dummy cycle");

  skip_tgt_a: assert property ($rose(redir_q.vld) && skip_taken |-> redir_q.tgt == pc_inc(pc_q))
    else $error("skip target is not the word after next");

  pcl_page_a: assert property (pcl_apply |=> pc_q == {$past(pc_q[PC_W-1:8]), $past(pcl_val)})
    else $error("low byte write disturbed the page");

  pcl_dummy_a: assert property (pcl_apply |=> dummy_cyc)
    else $error("no dummy cycle after low byte write");

  pcl_read_a: assert property (rd_wait_q && ap_q.addr == `IFP_OFS_PCL
    |=> hreadyout && hrdata == {24'h000000, $past(pc_q[7:0])})
    else $error("low byte read returned wrong value");

  acc_write_a: assert property (t3 && cls_q == ifp_pkg::CLS_ALU ##1 cyc_end |=> acc_q == $past(alu_q))
    else $error("accumulator not written from the unit");

endmodule : ifp_core

// *** hdl/ifp_params.svh ***
// offsets, field positions, reset values and timing counts of the fetch core
`ifndef IFP_PARAMS_SVH
`define IFP_PARAMS_SVH

`define IFP_OFS_PCL 8'h00
`define IFP_OFS_CTRL 8'h04
`define IFP_OFS_STAT 8'h08
`define IFP_OFS_PC 8'h0C
`define IFP_OFS_IR 8'h10

`define IFP_CTRL_RUN 0
`define IFP_CTRL_IRQEN 1
`define IFP_CTRL_RST 2'h1

`define IFP_PC_RST 14'h0000
`define IFP_ACC_RST 8'h00

`define IFP_OP_HI 15
`define IFP_OP_LO 13
`define IFP_AOP_HI 9
`define IFP_AOP_LO 8
`define IFP_IMM_HI 7
`define IFP_TGT_HI 12
`define IFP_PAGE_LO 8

`define IFP_PHASES 4

`endif

// *** hdl/ifp_phase_gen.sv ***
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
module ifp_phase_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output ifp_pkg::ifp_phase_t phase_q
);

  // phases never overlap: one hot, advancing one per hclk while run is set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_q <= ifp_pkg::IFP_T1;
    else if (run)
    begin
      case (phase_q)
        ifp_pkg::IFP_T1: phase_q <= ifp_pkg::IFP_T2;
        ifp_pkg::IFP_T2: phase_q <= ifp_pkg::IFP_T3;
        ifp_pkg::IFP_T3: phase_q <= ifp_pkg::IFP_T4;
        ifp_pkg::IFP_T4: phase_q <= ifp_pkg::IFP_T1;
        default: phase_q <= ifp_pkg::IFP_T1;
      endcase
    end
  end

  phase_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn) $onehot(phase_q))
    else $error("phase not one hot");

  phase_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && phase_q == ifp_pkg::IFP_T4) |=> phase_q == ifp_pkg::IFP_T1)
    else $error("phase did not wrap to first");

endmodule : ifp_phase_gen

// *** hdl/ifp_pkg.sv ***
// types shared by the fetch core and its sub-blocks
package ifp_pkg;

  typedef enum logic [3:0] {
    IFP_T1 = 4'h1,
    IFP_T2 = 4'h2,
    IFP_T3 = 4'h4,
    IFP_T4 = 4'h8
  } ifp_phase_t;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ALU = 3'h1,
    OP_SKZ = 3'h2,
    OP_SKNZ = 3'h3,
    OP_CALL = 3'h6,
    OP_JMP = 3'h7
  } ifp_op_t;

  typedef enum logic [5:0] {
    CLS_NOP = 6'h01,
    CLS_ALU = 6'h02,
    CLS_SKZ = 6'h04,
    CLS_SKNZ = 6'h08,
    CLS_JMP = 6'h10,
    CLS_CALL = 6'h20
  } ifp_cls_t;

  typedef enum logic [1:0] {
    ALU_MOV = 2'h0,
    ALU_ADD = 2'h1,
    ALU_AND = 2'h2,
    ALU_XOR = 2'h3
  } ifp_aluop_t;

  typedef struct packed {
    logic vld;
    logic push;
    logic [13:0] tgt;
  } ifp_redir_t;

  typedef struct packed {
    logic vld;
    logic wr;
    logic [7:0] addr;
  } ifp_ahb_ap_t;

endpackage : ifp_pkg
